// *** hdl/sar_adc_regs.svh ***
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: byte addresses on a 32-bit classic Wishbone bus, 100 MHz clock
// Notes: registers are 8 bits wide in the low byte lane
`ifndef SAR_ADC_REGS_SVH
`define SAR_ADC_REGS_SVH

`define OFS_CONTROL      8'h00
`define OFS_RESULT       8'h04
`define OFS_IRQ_STATUS   8'h08
`define OFS_IRQ_MASK     8'h0c
`define OFS_IRQ_POLARITY 8'h10

`define CTRL_CHAN_LSB    0
`define CTRL_DONE_BIT    3
`define CTRL_LADDER_BIT  4
`define POL_SRC_BIT      7
`define IRQ_CONV_BIT     0

`define CTRL_RESET       8'h08
`define RESULT_RESET     8'h00
`define IRQ_RESET        8'h00

`define CLK_PERIOD_NS    10
`define CONV_MAX_NS      12500
`define CONV_MAX_CYCLES  (`CONV_MAX_NS / `CLK_PERIOD_NS)
`define SETTLE_NS        40
`define SETTLE_CYCLES    ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** hdl/sar_adc_pkg.sv ***
// Purpose: types shared by the converter sequencer and its bench
// Assumes: classic Wishbone with 8-bit byte address
// Notes: constants live in sar_adc_regs.svh
package sar_adc_pkg;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_CLEAR  = 5'b00010,
    ST_SET    = 5'b00100,
    ST_SETTLE = 5'b01000,
    ST_DECIDE = 5'b10000
  } conv_state_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic       ladder_connect;
    logic [1:0] channel;
    logic [3:0] analog_enable;
    logic [7:0] trial_code;
  } analog_ctl_t;

endpackage : sar_adc_pkg

// *** hdl/sar_sync2.sv ***
// Purpose: two-flop synchroniser for a level from outside the clock domain
// Assumes: single clock, synchronous active-high reset
// Notes: first stage feeds the second stage only
`timescale 1ns/100ps
module sar_sync2 (
  // system
  input  wire logic clk,
  input  wire logic reset,
  // level
  input  wire logic din,
  output logic      dout
);
  logic meta_q;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end
    else
    begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule : sar_sync2

// *** hdl/sar_step_engine.sv ***
// Purpose: successive-approximation trial register
// Assumes: sequencer issues clear, then set/decide per bit from the top
// Notes: code_q drives the comparison ladder directly
`timescale 1ns/100ps
module sar_step_engine #(
  parameter int W = 8
) (
  // system
  input  wire logic         clk,
  input  wire logic         reset,
  // steps
  input  wire logic         clear,
  input  wire logic         set_bit,
  input  wire logic         decide,
  input  wire logic         keep,
  // state
  output logic [W-1:0]      code_q,
  output logic [$clog2(W)-1:0] idx_q,
  output logic              last
);
  assign last = (idx_q == '0);

  always_ff @(posedge clk)
  begin
    if (reset)
      code_q <= '0;
    else if (clear)
      code_q <= '0;
    else if (set_bit)
      code_q[idx_q] <= 1'b1;
    else if (decide && !keep)
      code_q[idx_q] <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (reset || clear)
      idx_q <= ($clog2(W))'(W - 1);
    else if (decide && !last)
      idx_q <= idx_q - 1'b1;
  end
endmodule : sar_step_engine

// *** hdl/sar_adc_sequencer.sv ***
// Purpose: 8-bit successive-approximation converter control with Wishbone registers
// Assumes: comparator and ladder are analog; comparator output is asynchronous
// Notes: offsets and fields in sar_adc_regs.svh
//
// Notes on behaviour
// - two low control bits pick analog input
// - writing zero to done bit starts
// - done bit low while converting, then high
// - ladder bit connects reference ladder to supply
// - trial code selects one of 256 steps
// - result cleared before any trial
// - first trial sets the top bit
// - keep bit if level below input
// - finish within 50 machine cycles
// - request bit set with done bit
// - source select routes completion to request
// - start does not clear request bit
// - result register is read-only
`timescale 1ns/100ps
`include "sar_adc_regs.svh"
module sar_adc_sequencer #(
  parameter int SETTLE_CYC = `SETTLE_CYCLES
) (
  // system
  input  wire logic                      clk,
  input  wire logic                      reset,
  // register bus
  input  wire sar_adc_pkg::wb_req_t      wb_req,
  output sar_adc_pkg::wb_rsp_t           wb_rsp,
  // analog side
  input  wire logic                      level_below_input,
  input  wire logic                      shared_ext_interrupt_three,
  output sar_adc_pkg::analog_ctl_t       analog_ctl,
  // interrupt
  output logic                           irq
);
  import sar_adc_pkg::*;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction : hit

  function automatic logic [3:0] chan_onehot(input logic [1:0] ch);
    chan_onehot = 4'h1 << ch;
  endfunction : chan_onehot

  conv_state_t st_q;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic [1:0]  chan_q;
  logic        ladder_q;
  logic        done_q;
  logic        src_sel_q;
  logic [7:0]  result_q;
  logic [7:0]  stat_q;
  logic [7:0]  mask_q;
  logic [3:0]  aen_q;
  logic        irq_q;
  logic [3:0]  settle_q;
  logic        keep_s;
  logic        ext_s;
  logic        ext_prev_q;
  logic [7:0]  code;
  logic [2:0]  idx;
  logic        last;
  logic        req_go;
  logic        wr_go;
  logic        rd_go;
  logic        start;
  logic        finish;
  logic        ext_event;
  logic [7:0]  stat_set;

  assign req_go = wb_req.cyc && wb_req.stb && !ack_q;
  assign wr_go  = req_go && wb_req.we && wb_req.sel[0];
  assign rd_go  = req_go && !wb_req.we;
  // a write of zero to the done bit is the start command
  assign start  = wr_go && hit(wb_req.adr, `OFS_CONTROL)
                  && !wb_req.dat[`CTRL_DONE_BIT];
  assign finish = (st_q == ST_DECIDE) && last;
  assign ext_event = ext_s && !ext_prev_q && !src_sel_q;
  assign stat_set  = {7'h00, (finish && src_sel_q) || ext_event};

  // comparator and external request cross in from the analog side
  sar_sync2 u_cmp_sync (
    .clk   (clk),
    .reset (reset),
    .din   (level_below_input),
    .dout  (keep_s)
  );

  sar_sync2 u_ext_sync (
    .clk   (clk),
    .reset (reset),
    .din   (shared_ext_interrupt_three),
    .dout  (ext_s)
  );

  sar_step_engine #(
    .W (8)
  ) u_engine (
    .clk     (clk),
    .reset   (reset),
    .clear   (st_q == ST_CLEAR),
    .set_bit (st_q == ST_SET),
    .decide  (st_q == ST_DECIDE),
    .keep    (keep_s),
    .code_q  (code),
    .idx_q   (idx),
    .last    (last)
  );

  // sequencer
  always_ff @(posedge clk)
  begin
    if (reset)
      st_q <= ST_IDLE;
    else if (start)
      st_q <= ST_CLEAR;
    else
    begin
      case (st_q)
        ST_IDLE:   st_q <= ST_IDLE;
        ST_CLEAR:  st_q <= ST_SET;
        ST_SET:    st_q <= ST_SETTLE;
        ST_SETTLE: st_q <= (settle_q == 4'h0) ? ST_DECIDE : ST_SETTLE;
        ST_DECIDE: st_q <= last ? ST_IDLE : ST_SET;
        default:   st_q <= ST_IDLE;
      endcase
    end
  end

  // wait is SETTLE_CYC cycles from the ladder step; the comparator synchroniser delay falls within it
  always_ff @(posedge clk)
  begin
    if (reset || st_q == ST_SET)
      settle_q <= 4'(SETTLE_CYC - 1);
    else if (settle_q != 4'h0)
      settle_q <= settle_q - 4'h1;
  end

  // control register
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      chan_q   <= 2'(`CTRL_RESET >> `CTRL_CHAN_LSB);
      ladder_q <= 1'b0;
    end
    else if (wr_go && hit(wb_req.adr, `OFS_CONTROL))
    begin
      chan_q   <= wb_req.dat[`CTRL_CHAN_LSB +: 2];
      ladder_q <= wb_req.dat[`CTRL_LADDER_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      done_q <= 1'(`CTRL_RESET >> `CTRL_DONE_BIT);
    else if (start)
      done_q <= 1'b0;
    else if (finish)
      done_q <= 1'b1;
  end

  // result is cleared on start and loaded on finish; bus writes never reach it
  always_ff @(posedge clk)
  begin
    if (reset)
      result_q <= `RESULT_RESET;
    else if (start)
      result_q <= 8'h00;
    else if (finish)
      result_q <= {code[7:1], keep_s ? code[0] : 1'b0};
  end

  // interrupt polarity, status and mask
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      src_sel_q <= 1'b0;
      mask_q    <= `IRQ_RESET;
    end
    else if (wr_go)
    begin
      if (hit(wb_req.adr, `OFS_IRQ_POLARITY))
        src_sel_q <= wb_req.dat[`POL_SRC_BIT];
      if (hit(wb_req.adr, `OFS_IRQ_MASK))
        mask_q <= wb_req.dat[7:0];
    end
  end

  // set wins over read-clear; start leaves the request alone
  always_ff @(posedge clk)
  begin
    if (reset)
      stat_q <= `IRQ_RESET;
    else if (rd_go && hit(wb_req.adr, `OFS_IRQ_STATUS))
      stat_q <= stat_set;
    else
      stat_q <= stat_q | stat_set;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ext_prev_q <= 1'b0;
      irq_q      <= 1'b0;
      aen_q      <= 4'h1;
    end
    else
    begin
      ext_prev_q <= ext_s;
      irq_q      <= |((stat_q | stat_set) & mask_q);
      aen_q      <= chan_onehot(chan_q);
    end
  end

  // bus answer: one wait state, unmapped reads return zero
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q  <= req_go;
      rdat_q <= 32'h0000_0000;
      if (rd_go)
      begin
        if (hit(wb_req.adr, `OFS_CONTROL))
          rdat_q[7:0] <= {3'h0, ladder_q, done_q, 1'b0, chan_q};
        else if (hit(wb_req.adr, `OFS_RESULT))
          rdat_q[7:0] <= result_q;
        else if (hit(wb_req.adr, `OFS_IRQ_STATUS))
          rdat_q[7:0] <= stat_q | stat_set;
        else if (hit(wb_req.adr, `OFS_IRQ_MASK))
          rdat_q[7:0] <= mask_q;
        else if (hit(wb_req.adr, `OFS_IRQ_POLARITY))
          rdat_q[7:0] <= {src_sel_q, 7'h00};
      end
    end
  end

  assign wb_rsp = '{ack: ack_q, dat: rdat_q};
  assign irq    = irq_q;
  // code picks one of 256 ladder taps
  assign analog_ctl = '{ladder_connect: ladder_q, channel: chan_q,
                        analog_enable: aen_q, trial_code: code};

  // checking helpers
  logic [10:0] busy_cnt_q;
  logic [2:0]  dec_idx_q;
  always_ff @(posedge clk)
  begin
    if (reset || start)
      busy_cnt_q <= 11'h000;
    else if (st_q != ST_IDLE)
      busy_cnt_q <= busy_cnt_q + 11'h001;
    dec_idx_q <= idx;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_start_done_low: assert property (start |=> !done_q)
    else $error("done bit not cleared by start");
  a_busy_done_low: assert property ((st_q != ST_IDLE) |-> !done_q)
    else $error("done bit high during conversion");
  a_clear_then_msb: assert property ((st_q == ST_CLEAR) && !start |=> (code == 8'h00) ##1 (code == 8'h80))
    else $error("result not cleared before first trial");
  a_bit_drop: assert property ((st_q == ST_DECIDE) && !keep_s && !start |=> !code[dec_idx_q])
    else $error("tested bit kept while level above input");
  a_last_finish: assert property ((st_q == ST_DECIDE) && last && !start |=> (st_q == ST_IDLE) && done_q)
    else $error("conversion did not end after bit zero");
  a_conv_bound: assert property (busy_cnt_q <= 11'(`CONV_MAX_CYCLES))
    else $error("conversion took too long");
  a_irq_with_done: assert property ($rose(done_q) && src_sel_q |-> stat_q[`IRQ_CONV_BIT])
    else $error("request bit not set with done bit");
  a_req_kept: assert property (start && stat_q[0] && !rd_go |=> stat_q[0])
    else $error("start cleared the request bit");
  a_result_ro: assert property (!start && !finish |=> $stable(result_q))
    else $error("result changed without a conversion");
  a_ladder_write: assert property (wr_go && hit(wb_req.adr, `OFS_CONTROL) |=> ladder_q == $past(wb_req.dat[4]))
    else $error("ladder bit not taken from write");
  a_chan_route: assert property (1'b1 |=> aen_q == chan_onehot($past(chan_q)))
    else $error("analog enable does not follow channel");
  a_restart: assert property (start |=> st_q == ST_CLEAR)
    else $error("start did not restart sequence");

  c_full_conv: cover property ((st_q == ST_CLEAR) ##[40:60] $rose(done_q));
  c_restart_busy: cover property ((st_q == ST_SETTLE) && start);
  c_irq_raise: cover property ($rose(irq));
  c_status_clear: cover property (rd_go && hit(wb_req.adr, `OFS_IRQ_STATUS) && stat_q[0]);
endmodule : sar_adc_sequencer

// *** testbench/sar_analog_model.sv ***
// Purpose: analog pins, channel selector, resistor ladder and comparator facing the sequencer
// Assumes: pin level n sits just above ladder step n, so a clean conversion returns n
// Notes: with the ladder off or no single pin selected the comparator chatters
`timescale 1ns/100ps
module sar_analog_model (
  // system
  input  wire logic                     clk,
  // control from the sequencer, pin levels from the bench
  input  wire sar_adc_pkg::analog_ctl_t analog_ctl,
  input  wire logic [31:0]              pin_levels,
  // comparator
  output logic                          level_below_input
);
  import sar_adc_pkg::*;
  logic       noise_q = 1'b0;
  logic [7:0] level;
  logic       hit;

  // a floating comparator must never look like a settled answer
  always_ff @(posedge clk)
    noise_q <= ~noise_q;

  always_comb
  begin
    level = 8'h00;
    hit   = 1'b0;
    for (int i = 0; i < 4; i++)
      if (analog_ctl.analog_enable == 4'(1 << i))
      begin
        level = pin_levels[8*i +: 8];
        hit   = 1'b1;
      end
  end

  assign level_below_input = (analog_ctl.ladder_connect && hit) ?
                             (analog_ctl.trial_code <= level) : noise_q;
endmodule : sar_analog_model

// *** testbench/test_sar_adc_sequencer.sv ***
// Purpose: self-checking bench for the converter sequencer and its registers
// Assumes: classic Wishbone, one request at a time, idle cycle between requests
// Notes: pin levels drawn from a fixed seed, corner codes added by hand
`timescale 1ns/100ps
`include "sar_adc_regs.svh"
module test_sar_adc_sequencer;
  import sar_adc_pkg::*;
  logic        clk;
  logic        reset;
  wb_req_t     wb_req;
  wb_rsp_t     wb_rsp;
  logic        level_below_input;
  logic        shared_ext_interrupt_three;
  analog_ctl_t analog_ctl;
  logic        irq;
  logic [31:0] pin_levels;
  logic [31:0] q;
  logic [7:0]  v;
  int          bad_count;
  int          checks;
  int          seed;
  logic [7:0]  ofs_tab [6] = '{`OFS_CONTROL, `OFS_RESULT, `OFS_IRQ_STATUS, `OFS_IRQ_MASK, `OFS_IRQ_POLARITY, 8'h14};
  logic [7:0]  rst_tab [6] = '{`CTRL_RESET, `RESULT_RESET, `IRQ_RESET, `IRQ_RESET, `IRQ_RESET, 8'h00};

  sar_adc_sequencer i_dut (.clk(clk), .reset(reset), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .level_below_input(level_below_input), .shared_ext_interrupt_three(shared_ext_interrupt_three),
    .analog_ctl(analog_ctl), .irq(irq));
  sar_analog_model i_analog (.clk(clk), .analog_ctl(analog_ctl), .pin_levels(pin_levels),
    .level_below_input(level_below_input));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic summarize;
    if (bad_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one classic cycle; an idle edge follows so the next request never shares a time step
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
    int t;
    t = 0;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'h1, dat: {24'h0, d}};
    @(posedge clk);
    while (wb_rsp.ack !== 1'b1 && t < 50)
    begin
      @(posedge clk);
      t++;
    end
    r = wb_rsp.dat;
    check(32'(t < 50), 32'h1);
    wb_req <= '0;
    @(posedge clk);
  endtask : wb_xfer

  // bit-by-bit trial, keeping a bit while its step is not above the pin
  function automatic logic [7:0] sar_expect(input logic [7:0] lvl);
    logic [7:0] c;
    c = 8'h00;
    for (int b = 7; b >= 0; b--)
    begin
      c[b] = 1'b1;
      if (c > lvl)
        c[b] = 1'b0;
    end
    return c;
  endfunction : sar_expect

  task automatic convert(input logic [1:0] ch, input logic [7:0] lvl, input logic irq_exp);
    logic [31:0] r;
    logic        irq_before;
    time         t0;
    int          k;
    pin_levels[8*ch +: 8] <= lvl;
    irq_before = irq;
    wb_xfer(1'b1, `OFS_CONTROL, 8'h10 | {6'h0, ch}, r);
    t0 = $time;
    check({31'h0, irq}, {31'h0, irq_before});
    // result stays unread while busy; the cleared trial code shows the clear step
    check({24'h0, analog_ctl.trial_code}, 32'h0);
    wb_xfer(1'b0, `OFS_CONTROL, 8'h00, r);
    check(r, {28'h1, 2'b00, ch});
    k = 0;
    while (r[3] !== 1'b1 && k < 600)
    begin
      wb_xfer(1'b0, `OFS_CONTROL, 8'h00, r);
      k++;
    end
    check(32'((($time - t0) / 10) <= `CONV_MAX_CYCLES), 32'h1);
    check(r, {28'h1, 2'b10, ch});
    check({28'h0, analog_ctl.analog_enable}, 32'(1 << ch));
    check({30'h0, analog_ctl.channel}, {30'h0, ch});
    check({31'h0, analog_ctl.ladder_connect}, 32'h1);
    check({31'h0, irq}, {31'h0, irq_exp});
    // ladder off once done is seen, done written as one so nothing restarts
    wb_xfer(1'b1, `OFS_CONTROL, 8'h08 | {6'h0, ch}, r);
    check({31'h0, analog_ctl.ladder_connect}, 32'h0);
    wb_xfer(1'b0, `OFS_RESULT, 8'h00, r);
    check(r, {24'h0, sar_expect(lvl)});
  endtask : convert

  initial
  begin
    #200000;
    bad_count++;
    summarize();
  end

  initial
  begin
    bad_count = 0;
    checks = 0;
    seed = 32'h244dd289;
    reset = 1'b1;
    wb_req = '0;
    shared_ext_interrupt_three = 1'b0;
    pin_levels = 32'h0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 6; i++)
    begin
      wb_xfer(1'b0, ofs_tab[i], 8'h00, q);
      check(q, {24'h0, rst_tab[i]});
    end
    // the pin counts while source select is clear, and not once it is set
    for (int s = 0; s < 2; s++)
    begin
      shared_ext_interrupt_three <= 1'b1;
      repeat (4) @(posedge clk);
      shared_ext_interrupt_three <= 1'b0;
      repeat (4) @(posedge clk);
      wb_xfer(1'b0, `OFS_IRQ_STATUS, 8'h00, q);
      check(q, 32'(s == 0));
      wb_xfer(1'b1, `OFS_IRQ_POLARITY, 8'h80, q);
      wb_xfer(1'b1, `OFS_IRQ_MASK, 8'h01, q);
    end
    for (int i = 0; i < 8; i++)
    begin
      v = 8'($random(seed));
      convert(2'(i), v, 1'b1);
      wb_xfer(1'b0, `OFS_IRQ_STATUS, 8'h00, q);
      check(q, 32'h1);
      wb_xfer(1'b0, `OFS_IRQ_STATUS, 8'h00, q);
      check({q[31:1], irq}, 32'h0);
    end
    convert(2'd3, 8'hff, 1'b1);
    convert(2'd2, 8'h00, 1'b1);
    convert(2'd0, 8'h80, 1'b1);
    // restart in mid-run: the second start wins
    wb_xfer(1'b1, `OFS_CONTROL, 8'h11, q);
    repeat (12) @(posedge clk);
    convert(2'd1, 8'h7f, 1'b1);
    wb_xfer(1'b1, `OFS_RESULT, 8'h5a, q);
    wb_xfer(1'b0, `OFS_RESULT, 8'h00, q);
    check(q, 32'h7f);
    // writing one to the done bit must not start anything
    wb_xfer(1'b0, `OFS_IRQ_STATUS, 8'h00, q);
    wb_xfer(1'b1, `OFS_CONTROL, 8'h19, q);
    repeat (60) @(posedge clk);
    wb_xfer(1'b0, `OFS_IRQ_STATUS, 8'h00, q);
    check(q, 32'h0);
    wb_xfer(1'b1, `OFS_IRQ_MASK, 8'h00, q);
    convert(2'd2, 8'h3c, 1'b0);
    wb_xfer(1'b0, `OFS_IRQ_STATUS, 8'h00, q);
    check(q, 32'h1);
    wb_xfer(1'b1, `OFS_CONTROL, 8'h1a, q);
    check({31'h0, analog_ctl.ladder_connect}, 32'h1);
    summarize();
  end
endmodule : test_sar_adc_sequencer
